// ### inc/timer_pwm_unit_pkg.sv
package timer_pwm_unit_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH = 8;  // Channels 1..8 live at index 0..7
  localparam int AW  = 8;
  localparam int DW  = 16;

  // ----------------------------------------------------------------
  // Register word addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_MOD     = 8'h01;
  localparam logic [7:0] ADDR_COUNT   = 8'h02;
  localparam logic [7:0] ADDR_FLAGS   = 8'h03;
  localparam logic [7:0] ADDR_CH_CTRL = 8'h10;  // Plus channel index
  localparam logic [7:0] ADDR_CH_VAL  = 8'h18;  // Plus channel index

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_PS_LSB    = 0;
  localparam int CTRL_CLKS_LSB  = 3;
  localparam int CTRL_CENTER_PWM_SELECT_BIT = 5;
  localparam int CHC_ELS_LSB    = 0;
  localparam int CHC_MODE_LSB   = 2;
  localparam int FLAG_OVF_BIT   = 8;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CLKS_NONE   = 2'h0;
  localparam logic [1:0] CLKS_BUS    = 2'h1;
  localparam logic [1:0] CLKS_FIXED  = 2'h2;
  localparam logic [1:0] CLKS_EXT    = 2'h3;
  localparam logic [1:0] ELS_OFF     = 2'h0;
  localparam logic [1:0] ELS_TOGGLE  = 2'h1;
  localparam logic [1:0] ELS_CLEAR   = 2'h2;
  localparam logic [1:0] ELS_SET     = 2'h3;
  localparam logic [1:0] MODE_CAPT   = 2'h0;
  localparam logic [1:0] MODE_CMP    = 2'h1;
  localparam logic [15:0] MOD_RST    = 16'h0000;
  localparam logic [15:0] VAL_RST    = 16'h0000;

  typedef enum logic [4:0] {
    CHF_OFF        = 5'h01,
    CHF_CAPTURE    = 5'h02,
    CHF_COMPARE    = 5'h04,
    CHF_EDGE_PWM   = 5'h08,
    CHF_CENTER_PWM = 5'h10
  } chan_func_t;

endpackage

// ### design/timer_pwm_unit.sv
// What this block does
// R1 - Software picks counter clock source
// R2 - External clock synchronised, max quarter bus rate
// R3 - Software avoids channel I/O on clock pin
// R4 - Software-timer compare works with external clock
// R5 - Pin released when edge select or source zero
// R6 - Center select drives all active channels center-aligned
// R7 - Mode field picks capture, compare, edge PWM
// R8 - Capture pin is edge input, edge select polarity
// R9 - Capture input synchronised to bus clock
// R10 - Capture pulses held four bus clocks
// R11 - Compare drives pin, toggles/clears/sets on match
// R12 - Toggle keeps previous level until next match
// R13 - Edge PWM 1:0 high at start, low match
// R14 - Edge PWM low bit set inverts polarity
// R15 - Center PWM 1:0 clear up, set down
// R16 - Center PWM low bit set inverts polarity
// R17 - Eight channels, each with own pin
// R18 - Source codes none, bus, fixed, external
// R19 - Edge PWM period is modulo plus one
// R20 - Center counter counts up then down
// R21 - Prescaler divides by power of two
// R22 - Compare actions toggle, clear, set
// R23 - Event flag set in recognition cycle
`timescale 1ns/10ps
module timer_pwm_unit (
  input  wire logic                               MCLK,
  input  wire logic                               RST_N,
  input  wire logic [timer_pwm_unit_pkg::AW-1:0]  ADDR,
  input  wire logic [timer_pwm_unit_pkg::DW-1:0]  WDATA,
  input  wire logic                               WR,
  input  wire logic                               RD,
  output logic      [timer_pwm_unit_pkg::DW-1:0]  RDATA,
  input  wire logic                               EXT_CLK_PIN,
  input  wire logic                               FIXED_CLK,
  input  wire logic [timer_pwm_unit_pkg::NCH-1:0] CH_IN,
  output logic      [timer_pwm_unit_pkg::NCH-1:0] CH_OUT,
  output logic      [timer_pwm_unit_pkg::NCH-1:0] CH_OE
);
  import timer_pwm_unit_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]                ps;
    logic [1:0]                clks;
    logic                      center_pwm_select;
    logic [15:0]               modv;
    logic [15:0]               cnt;
    logic                      down;
    logic [6:0]                pre;
    logic [FLAG_OVF_BIT:0]     flags;
    logic [NCH-1:0][1:0]       els;
    logic [NCH-1:0][1:0]       mode;
    logic [NCH-1:0][15:0]      val;
    logic [2:0]                ext_s;
    logic [2:0]                fix_s;
    logic [NCH-1:0]            ch_s1;
    logic [NCH-1:0]            ch_s2;
    logic [NCH-1:0]            ch_s3;
    logic [NCH-1:0]            out;
    logic [NCH-1:0]            oe;
    logic [DW-1:0]             rdata;
  } state_t;

  state_t         st_reg;
  state_t         st_next;
  logic           ext_rise;
  logic           fix_rise;
  logic           src_tick;
  logic           cnt_tick;
  logic           ovf_ev;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] cmp_ev;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  chan_func_t     func [NCH];

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  // Pin function of one channel from the shared and channel fields
  function automatic chan_func_t chan_func(input logic center_pwm_select, input logic [1:0] clks,
                                           input logic [1:0] mode, input logic [1:0] els);
    if (clks == CLKS_NONE || els == ELS_OFF)
      return CHF_OFF;   // R5
    else if (center_pwm_select)
      return CHF_CENTER_PWM;   // R6
    else if (mode == MODE_CAPT)
      return CHF_CAPTURE;   // R7
    else if (mode == MODE_CMP)
      return CHF_COMPARE;   // R7
    else
      return CHF_EDGE_PWM;   // R7
  endfunction

  // Divider mask for the prescale select field
  function automatic logic [6:0] pre_mask(input logic [2:0] ps);
    return 7'((8'h01 << ps) - 8'h01);   // R21
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    ovf_ev  = 1'b0;
    // Two-flop synchronisers plus a third stage for edge detection
    st_next.ext_s = {st_reg.ext_s[1:0], EXT_CLK_PIN};   // R2
    st_next.fix_s = {st_reg.fix_s[1:0], FIXED_CLK};
    st_next.ch_s1 = CH_IN;   // R9
    st_next.ch_s2 = st_reg.ch_s1;
    st_next.ch_s3 = st_reg.ch_s2;
    ext_rise = st_reg.ext_s[1] & ~st_reg.ext_s[2];
    fix_rise = st_reg.fix_s[1] & ~st_reg.fix_s[2];
    rise     = st_reg.ch_s2 & ~st_reg.ch_s3;
    fall     = ~st_reg.ch_s2 & st_reg.ch_s3;

    // Clock source selection
    case (st_reg.clks)   // R1 R18
      CLKS_BUS:   src_tick = 1'b1;
      CLKS_FIXED: src_tick = fix_rise;
      CLKS_EXT:   src_tick = ext_rise;
      default:    src_tick = 1'b0;
    endcase

    // Prescaler: counter advances on every 2^ps source ticks
    cnt_tick = src_tick && ((st_reg.pre & pre_mask(st_reg.ps)) == pre_mask(st_reg.ps));   // R21
    if (src_tick)
      st_next.pre = st_reg.pre + 7'h01;

    // Counter
    if (cnt_tick) begin
      if (!st_reg.center_pwm_select) begin
        if (st_reg.cnt == st_reg.modv && st_reg.modv != 16'h0000) begin
          st_next.cnt = 16'h0000;   // R19
        end else begin
          st_next.cnt = st_reg.cnt + 16'h0001;
        end
        ovf_ev = (st_next.cnt == 16'h0000);
      end else if (st_reg.modv != 16'h0000) begin
        if (!st_reg.down) begin
          if (st_reg.cnt >= st_reg.modv) begin
            st_next.down = 1'b1;   // R20
            st_next.cnt  = st_reg.cnt - 16'h0001;
          end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
          end
        end else if (st_reg.cnt == 16'h0000) begin
          st_next.down = 1'b0;   // R20
          st_next.cnt  = 16'h0001;
          ovf_ev       = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt - 16'h0001;
        end
      end
    end

    // Register writes; flag clears come before the sets below
    if (WR) begin
      case (ADDR)
        ADDR_CTRL: begin
          st_next.ps    = WDATA[CTRL_PS_LSB +: 3];
          st_next.clks  = WDATA[CTRL_CLKS_LSB +: 2];
          st_next.center_pwm_select = WDATA[CTRL_CENTER_PWM_SELECT_BIT];
        end
        ADDR_MOD:   st_next.modv = WDATA;
        ADDR_COUNT: begin
          st_next.cnt  = 16'h0000;
          st_next.down = 1'b0;
          st_next.pre  = 7'h00;
        end
        ADDR_FLAGS: st_next.flags = st_reg.flags & ~WDATA[FLAG_OVF_BIT:0];
        default: begin
          if (ADDR[7:3] == ADDR_CH_CTRL[7:3]) begin
            st_next.els[ADDR[2:0]]  = WDATA[CHC_ELS_LSB +: 2];
            st_next.mode[ADDR[2:0]] = WDATA[CHC_MODE_LSB +: 2];
          end else if (ADDR[7:3] == ADDR_CH_VAL[7:3]) begin
            st_next.val[ADDR[2:0]] = WDATA;
          end
        end
      endcase
    end
    // Overflow set wins over a clear in the same cycle
    if (ovf_ev)
      st_next.flags[FLAG_OVF_BIT] = 1'b1;

    // Channels
    for (int i = 0; i < NCH; i++) begin   // R17
      func[i]   = chan_func(st_reg.center_pwm_select, st_reg.clks, st_reg.mode[i], st_reg.els[i]);
      cmp_ev[i] = 1'b0;
      cap_ev[i] = 1'b0;
      st_next.oe[i] = (func[i] != CHF_OFF);   // R5 R6 R8 R11 R15
      case (func[i])
        CHF_CAPTURE: begin
          // Edge select 01 rising, 10 falling, 11 either
          cap_ev[i] = (st_reg.els[i][0] & rise[i]) | (st_reg.els[i][1] & fall[i]);   // R8 R9
          st_next.oe[i] = 1'b0;   // R8
          st_next.out[i] = st_reg.ch_s2[i];
          if (cap_ev[i])
            st_next.val[i] = st_reg.cnt;
        end
        CHF_COMPARE: begin
          cmp_ev[i] = cnt_tick && st_reg.cnt == st_reg.val[i];
          if (cmp_ev[i]) begin
            case (st_reg.els[i])   // R11 R22
              ELS_TOGGLE: st_next.out[i] = ~st_reg.out[i];   // R12
              ELS_CLEAR:  st_next.out[i] = 1'b0;
              default:    st_next.out[i] = 1'b1;
            endcase
          end
        end
        CHF_EDGE_PWM: begin
          cmp_ev[i] = cnt_tick && st_reg.cnt == st_reg.val[i];
          if (cnt_tick && st_reg.cnt == 16'h0000)
            st_next.out[i] = ~st_reg.els[i][0];   // R13 R14
          if (cmp_ev[i])
            st_next.out[i] = st_reg.els[i][0];   // R13 R14
        end
        CHF_CENTER_PWM: begin
          cmp_ev[i] = cnt_tick && st_reg.cnt == st_reg.val[i];
          if (cmp_ev[i])
            st_next.out[i] = st_reg.els[i][0] ^ st_reg.down;   // R15 R16
        end
        default: begin
          // Released pin: follow its level so toggle starts from it
          st_next.out[i] = st_reg.ch_s2[i];   // R12
          cmp_ev[i] = !st_reg.center_pwm_select && st_reg.mode[i] == MODE_CMP && st_reg.clks != CLKS_NONE
                      && cnt_tick && st_reg.cnt == st_reg.val[i];   // R4
        end
      endcase
      if (cap_ev[i] || cmp_ev[i])
        st_next.flags[i] = 1'b1;   // R23
    end

    // Read data stands only in the cycle after the strobe
    st_next.rdata = '0;
    if (RD) begin
      case (ADDR)
        ADDR_CTRL:  st_next.rdata = {10'h000, st_reg.center_pwm_select, st_reg.clks, st_reg.ps};
        ADDR_MOD:   st_next.rdata = st_reg.modv;
        ADDR_COUNT: st_next.rdata = st_reg.cnt;
        ADDR_FLAGS: st_next.rdata = {7'h00, st_reg.flags};
        default: begin
          if (ADDR[7:3] == ADDR_CH_CTRL[7:3])
            st_next.rdata = {12'h000, st_reg.mode[ADDR[2:0]], st_reg.els[ADDR[2:0]]};
          else if (ADDR[7:3] == ADDR_CH_VAL[7:3])
            st_next.rdata = st_reg.val[ADDR[2:0]];
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg      <= '0;
      st_reg.modv <= MOD_RST;
      st_reg.val  <= {NCH{VAL_RST}};
      st_reg.ch_s1 <= '1;   // Released pins idle high, so no false edge
      st_reg.ch_s2 <= '1;
      st_reg.ch_s3 <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign RDATA  = st_reg.rdata;
  assign CH_OUT = st_reg.out;
  assign CH_OE  = st_reg.oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  chk_stopped_count: assert property (st_reg.clks == CLKS_NONE && !WR |=> $stable(st_reg.cnt))   // R18
    else $error("counter moved with no clock source");
  chk_bus_rate_step: assert property (st_reg.clks == CLKS_BUS && st_reg.ps == 3'h0 && !st_reg.center_pwm_select
      && !WR && st_reg.cnt != st_reg.modv |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001)   // R1
    else $error("bus rate counter did not step");
  chk_release_pin: assert property (st_reg.els[0] == ELS_OFF || st_reg.clks == CLKS_NONE |=> !CH_OE[0])   // R5
    else $error("channel kept pin while released");
  chk_center_drive: assert property (st_reg.center_pwm_select && st_reg.els[0] != ELS_OFF
      && st_reg.clks != CLKS_NONE |=> CH_OE[0])   // R6
    else $error("center pwm pin not driven");
  chk_capture_value: assert property (cap_ev[7] |=> st_reg.val[7] == $past(st_reg.cnt) && st_reg.flags[7])   // R9
    else $error("capture lost value or flag");
  chk_edge_start: assert property (func[4] == CHF_EDGE_PWM && st_reg.els[4] == ELS_CLEAR && cnt_tick
      && st_reg.cnt == 16'h0000 && st_reg.val[4] != 16'h0000 |=> CH_OUT[4])   // R13
    else $error("edge pwm did not rise at period start");
  chk_toggle_match: assert property (func[1] == CHF_COMPARE && st_reg.els[1] == ELS_TOGGLE && cmp_ev[1]
      |=> CH_OUT[1] != $past(CH_OUT[1]))   // R12
    else $error("compare toggle missed");
  chk_ext_sync: assert property (st_reg.clks == CLKS_EXT && src_tick
      |-> $past(EXT_CLK_PIN, 2) && !$past(EXT_CLK_PIN, 3))   // R2
    else $error("external tick without synchronised edge");
  chk_center_turn: assert property (st_reg.center_pwm_select && cnt_tick && !st_reg.down && st_reg.modv != 16'h0000
      && st_reg.cnt == st_reg.modv && !WR |=> st_reg.down)   // R20
    else $error("center counter did not turn at modulo");
  chk_edge_wrap: assert property (!st_reg.center_pwm_select && cnt_tick && st_reg.modv != 16'h0000
      && st_reg.cnt == st_reg.modv |=> st_reg.cnt == 16'h0000 && st_reg.flags[FLAG_OVF_BIT])   // R19
    else $error("edge counter did not wrap with overflow flag");

endmodule // timer_pwm_unit

// ### bench/pin_load_model.sv
`timescale 1ns/10ps
module pin_load_model (
  input  wire logic                               mclk,
  input  wire logic [timer_pwm_unit_pkg::NCH-1:0] ch_out,
  input  wire logic [timer_pwm_unit_pkg::NCH-1:0] ch_oe,
  output logic      [timer_pwm_unit_pkg::NCH-1:0] ch_in,
  output logic                                    ext_clk,
  output logic                                    fixed_clk
);
  import timer_pwm_unit_pkg::*;
  logic [NCH-1:0] pull_low;

  // Driven pins read back, released pins sit on their pull-ups
  assign ch_in = (ch_oe & ch_out) | (~ch_oe & ~pull_low);

  // Idle levels
  initial begin
    pull_low  = '0;
    ext_clk   = 1'b0;
    fixed_clk = 1'b0;
  end

  // Clock burst of eight bus clocks a period on its own line, low between bursts
  task automatic clk_burst(input logic fix, input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      {fixed_clk, ext_clk} <= fix ? 2'b10 : 2'b01;
      repeat (4) @(posedge mclk);
      {fixed_clk, ext_clk} <= 2'b00;
    end
  endtask

  // Low pulse of four bus clocks on a released pin
  task automatic low_pulse(input int ch);
    @(posedge mclk);
    pull_low[ch] <= 1'b1;
    repeat (4) @(posedge mclk);
    pull_low[ch] <= 1'b0;
  endtask
endmodule  // pin_load_model

// ### bench/timer_pwm_unit_test.sv
`timescale 1ns/10ps
module timer_pwm_unit_test;
  import timer_pwm_unit_pkg::*;
  logic           mclk, rst_n, wr, rd, ext_clk, fixed_clk;
  logic [AW-1:0]  addr;
  logic [DW-1:0]  wdata, rdata;
  logic [NCH-1:0] ch_in, ch_out, ch_oe;
  int             fails, n_checks, cycles, m, v;
  int             hi [NCH];

  timer_pwm_unit i_timer_pwm_unit (
    .MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .EXT_CLK_PIN(ext_clk), .FIXED_CLK(fixed_clk),
    .CH_IN(ch_in), .CH_OUT(ch_out), .CH_OE(ch_oe));
  pin_load_model i_pin_load_model (
    .mclk(mclk), .ch_out(ch_out), .ch_oe(ch_oe), .ch_in(ch_in),
    .ext_clk(ext_clk), .fixed_clk(fixed_clk));

  // Clock, and a cycle ceiling against hangs
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      summarize();
    end
  end

  // Verdict and end of run
  task automatic summarize();
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] x);
    @(posedge mclk);
    addr  <= a;
    wdata <= x;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // Read, data taken in the cycle after the strobe
  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] x);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    @(negedge mclk);
    n_checks++;
    if (rdata !== x) begin
      fails++;
      $display("Error at %0t: read %h gave %h, expected %h", $time, a, rdata, x);
    end
  endtask

  // Pin levels or enables under a mask
  task automatic pin_chk(input logic oe, input logic [NCH-1:0] mask, input logic [NCH-1:0] x);
    @(negedge mclk);
    n_checks++;
    if (((oe ? ch_oe : ch_out) & mask) !== x) begin
      fails++;
      $display("Error at %0t: pins %b, expected %b", $time, oe ? ch_oe : ch_out, x);
    end
  endtask

  // Counted high cycles
  task automatic cnt_chk(input int got, input int x);
    n_checks++;
    if (got != x) begin
      fails++;
      $display("Error at %0t: high cycles %0d, expected %0d", $time, got, x);
    end
  endtask

  // Channel and timer set-up, counter restarted after each control write
  task automatic ch_cfg(input int ch, input logic [1:0] md, input logic [1:0] el, input logic [15:0] val);
    wr_reg(8'(ADDR_CH_CTRL + ch), {12'h000, md, el});
    wr_reg(8'(ADDR_CH_VAL + ch), val);
  endtask
  task automatic ctrl(input logic cp, input logic [1:0] cs, input logic [2:0] ps);
    wr_reg(ADDR_CTRL, {10'h000, cp, cs, ps});
    wr_reg(ADDR_COUNT, 16'h0000);
  endtask

  // High cycles of every pin over a window
  task automatic measure(input int w);
    for (int i = 0; i < NCH; i++) hi[i] = 0;
    repeat (w) begin
      @(negedge mclk);
      for (int i = 0; i < NCH; i++) if (ch_out[i] === 1'b1) hi[i]++;
    end
  endtask

  // High cycles per period for the two pulse shapes
  function automatic int edge_hi(int m, int v, logic low);
    return low ? m + 1 - v : v;
  endfunction
  function automatic int ctr_hi(int m, int v, logic low);
    return low ? 2 * (m - v) : 2 * v;
  endfunction

  // Main sequence
  initial begin
    {wr, rd, rst_n} = 3'b000;
    addr  = '0;
    wdata = '0;
    {fails, n_checks, cycles} = '0;
    void'($urandom(32'hC60A9FA0));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    pin_chk(1'b1, 8'hFF, 8'h00);
    rd_chk(ADDR_CTRL, 16'h0000);
    rd_chk(ADDR_MOD, MOD_RST);
    rd_chk(8'(ADDR_CH_VAL + $urandom_range(7)), VAL_RST);
    rd_chk(8'hF0, 16'h0000);
    // No clock selected
    ch_cfg(0, MODE_CMP, ELS_SET, 16'h0003);
    ctrl(1'b0, CLKS_NONE, 3'h0);
    repeat (20) @(posedge mclk);
    rd_chk(ADDR_COUNT, 16'h0000);
    pin_chk(1'b1, 8'hFF, 8'h00);
    // External and fixed clocks, software timer beside the clock pin
    ch_cfg(0, MODE_CMP, ELS_OFF, 16'h0005);
    ctrl(1'b0, CLKS_EXT, 3'h0);
    wr_reg(ADDR_FLAGS, 16'hFFFF);
    i_pin_load_model.clk_burst(1'b0, 20);
    repeat (8) @(posedge mclk);
    rd_chk(ADDR_COUNT, 16'h0014);
    rd_chk(ADDR_FLAGS, 16'h0001);
    pin_chk(1'b1, 8'hFF, 8'h00);
    ctrl(1'b0, CLKS_FIXED, 3'h0);
    i_pin_load_model.clk_burst(1'b1, 15);
    repeat (8) @(posedge mclk);
    rd_chk(ADDR_COUNT, 16'h000F);
    // Output compare actions at one match
    ch_cfg(1, MODE_CMP, ELS_TOGGLE, 16'h012C);
    ch_cfg(2, MODE_CMP, ELS_CLEAR, 16'h012C);
    ch_cfg(3, MODE_CMP, ELS_SET, 16'h012C);
    ctrl(1'b0, CLKS_BUS, 3'h0);
    wr_reg(ADDR_FLAGS, 16'hFFFF);
    pin_chk(1'b1, 8'h0E, 8'h0E);
    pin_chk(1'b0, 8'h0E, 8'h0E);
    repeat (320) @(posedge mclk);
    pin_chk(1'b0, 8'h0E, 8'h08);
    rd_chk(ADDR_FLAGS, 16'h000F);
    // Edge-aligned pulses of both polarities for every prescale setting
    for (int ps = 0; ps < 8; ps++) begin
      m = 4 + $urandom_range(16);
      v = 1 + $urandom_range(m - 1);
      wr_reg(ADDR_MOD, 16'(m));
      ch_cfg(4, 2'h2, ELS_CLEAR, 16'(v));
      ch_cfg(5, 2'h3, ELS_SET, 16'(v));
      ctrl(1'b0, CLKS_BUS, 3'(ps));
      repeat (2 * (m + 1) << ps) @(posedge mclk);
      measure(3 * (m + 1) << ps);
      cnt_chk(hi[4], 3 * edge_hi(m, v, 1'b0) << ps);
      cnt_chk(hi[5], 3 * edge_hi(m, v, 1'b1) << ps);
    end
    // Center-aligned on every active channel
    m = 6 + $urandom_range(20);
    v = 1 + $urandom_range(m - 2);
    wr_reg(ADDR_MOD, 16'(m));
    ch_cfg(4, 2'h2, ELS_CLEAR, 16'(v));
    ch_cfg(5, 2'h2, ELS_SET, 16'(v));
    ch_cfg(6, MODE_CAPT, ELS_TOGGLE, 16'h0000);
    ctrl(1'b1, CLKS_BUS, 3'h0);
    repeat (4 * m) @(posedge mclk);
    measure(6 * m);
    cnt_chk(hi[4], 3 * ctr_hi(m, v, 1'b0));
    cnt_chk(hi[5], 3 * ctr_hi(m, v, 1'b1));
    pin_chk(1'b1, 8'hF1, 8'h70);
    // Capture on each edge selection, pin left as an input
    for (int i = 0; i < 7; i++) ch_cfg(i, MODE_CAPT, ELS_OFF, 16'h0000);
    wr_reg(ADDR_MOD, 16'h0000);
    ctrl(1'b0, CLKS_BUS, 3'h0);
    for (int e = 1; e < 4; e++) begin
      ch_cfg(7, MODE_CAPT, 2'(e), 16'h0000);
      wr_reg(ADDR_FLAGS, 16'hFFFF);
      pin_chk(1'b1, 8'hFF, 8'h00);
      i_pin_load_model.low_pulse(7);
      repeat (8) @(posedge mclk);
      rd_chk(ADDR_FLAGS, 16'h0080);
    end
    summarize();
  end
endmodule  // timer_pwm_unit_test
